// ---- design/ppsr_registers.sv ----
// Port status register bank of a three-port cable physical layer
`timescale 1ns/100ps
`default_nettype none

module ppsr_registers #(
   parameter int NUM_PORTS = 3,
   parameter int unsigned DEBOUNCE_CYCLES = ppsr_pkg::DEBOUNCE_CYCLES,
   parameter logic [1:0] REVISION = 2'h0 // Arbitrary value
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   // Register access from the link-layer side
   input wire logic [3:0] reg_addr_in,
   input wire logic reg_rd_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   // Pins
   input wire logic cable_power_in,
   input wire logic bm_capable_in,
   input wire logic [NUM_PORTS-1:0] cable_connect_in,
   input wire logic [2*NUM_PORTS-1:0] cable_pair_a_in,
   input wire logic [2*NUM_PORTS-1:0] cable_pair_b_in,
   // Arbitration controller, same clock
   input wire logic bus_reset_in,
   input wire logic treeid_done_in,
   input wire logic selfid_done_in,
   input wire logic is_root_in,
   input wire logic [5:0] node_address_in,
   input wire logic [NUM_PORTS-1:0] child_in,
   input wire logic [NUM_PORTS-1:0] port_busy_in,
   input wire logic loop_timeout_in,
   input wire logic gap_cfg_valid_in,
   input wire logic [5:0] gap_cfg_in,
   // To arbitration controller
   output logic bus_reset_out,
   output logic ports_quiet_out,
   output logic [NUM_PORTS-1:0] conn_status_out,
   output logic [NUM_PORTS-1:0] startup_child_out,
   output logic bm_capable_out,
   output logic [5:0] gap_count_out
);

   typedef enum logic [2:0] {
      ST_INIT = 3'b001,
      ST_QUIET = 3'b010,
      ST_RUN = 3'b100
   } ppsr_state_e;

   initial begin
      if (NUM_PORTS < 1 || NUM_PORTS > ppsr_pkg::MAX_PORTS) $error("ppsr_registers: NUM_PORTS must be 1 to 3");
   end

   // -----------------------------------------------------------------
   // Pin synchronisers
   // -----------------------------------------------------------------
   logic cps_low_sync, cps_sync, bm_sync;
   logic [NUM_PORTS-1:0] conn_sync;
   logic [2*NUM_PORTS-1:0] pa_sync, pb_sync;

   ppsr_sync2 #(.WIDTH(2 + 5 * NUM_PORTS)) u_sync (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .async_in({~cable_power_in, bm_capable_in, cable_connect_in, cable_pair_a_in, cable_pair_b_in}),
      .sync_out({cps_low_sync, bm_sync, conn_sync, pa_sync, pb_sync})
   );

   // Carried inverted so a cleared synchroniser reads power good, no false interrupt
   assign cps_sync = ~cps_low_sync;

   // -----------------------------------------------------------------
   // Connection debounce
   // -----------------------------------------------------------------
   logic [NUM_PORTS-1:0] stable, conn_evt, disc_evt;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
         ppsr_debounce #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_deb (
            .ref_clk_in(ref_clk_in),
            .sys_rst_in(sys_rst_in),
            .raw_connect_in(conn_sync[gi]),
            .stable_out(stable[gi]),
            .connect_evt_out(conn_evt[gi]),
            .disconnect_evt_out(disc_evt[gi])
         );
      end
   endgenerate

   // -----------------------------------------------------------------
   // Start-up sequence and bus reset requests
   // -----------------------------------------------------------------
   ppsr_state_e state_reg, state_next;
   logic bus_reset_reg, bus_reset_next;
   logic own_reset_reg, own_reset_next;
   logic write_ibr;

   assign write_ibr = reg_wr_in && reg_addr_in == ppsr_pkg::ADDR_BUS_CONTROL && reg_wdata_in[ppsr_pkg::BUS_IBR_BIT];

   always_comb begin
      state_next = state_reg;
      bus_reset_next = 1'b0;
      own_reset_next = own_reset_reg;
      case (state_reg)
         ST_INIT: begin
            // First reset runs with every port seen as unplugged
            bus_reset_next = 1'b1;
            state_next = ST_QUIET;
         end
         ST_QUIET: begin
            if (selfid_done_in) begin
               state_next = ST_RUN;
               bus_reset_next = |stable;
            end
         end
         ST_RUN: begin
            // Connect events wait for debounce, losses do not
            bus_reset_next = write_ibr || (|conn_evt) || (|disc_evt);
         end
         default: begin
            state_next = ST_INIT;
         end
      endcase
      if (bus_reset_in) own_reset_next = 1'b0;
      if (bus_reset_next) own_reset_next = 1'b1;
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         state_reg <= ST_INIT;
         bus_reset_reg <= 1'b0;
         own_reset_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         bus_reset_reg <= bus_reset_next;
         own_reset_reg <= own_reset_next;
      end
   end

   logic startup;
   assign startup = state_reg != ST_RUN;
   assign bus_reset_out = bus_reset_reg;
   assign ports_quiet_out = startup;
   assign conn_status_out = startup ? '0 : stable;
   assign startup_child_out = startup ? '1 : '0;
   assign bm_capable_out = bm_sync;

   // -----------------------------------------------------------------
   // Register state
   // -----------------------------------------------------------------
   logic [5:0] node_addr_reg, node_addr_next;
   logic root_reg, root_next;
   logic root_hold_reg, root_hold_next;
   logic ibr_reg, ibr_next;
   logic [5:0] gap_reg, gap_next;
   logic gap_seen_reg, gap_seen_next;
   logic sf_reg, sf_next;
   logic pd_reg, pd_next;
   logic loop_int_reg, loop_int_next;
   logic cps_int_reg, cps_int_next;
   logic ir_reg, ir_next;
   logic [NUM_PORTS-1:0] child_reg, child_next;
   logic [NUM_PORTS-1:0] con_reg, con_next;
   logic [2*NUM_PORTS-1:0] la_reg, la_next;
   logic [2*NUM_PORTS-1:0] lb_reg, lb_next;
   logic wr_bus, wr_cfg, wr_int;

   assign wr_bus = reg_wr_in && reg_addr_in == ppsr_pkg::ADDR_BUS_CONTROL;
   assign wr_cfg = reg_wr_in && reg_addr_in == ppsr_pkg::ADDR_NODE_CONFIG;
   assign wr_int = reg_wr_in && reg_addr_in == ppsr_pkg::ADDR_INT_FLAGS;

   always_comb begin
      node_addr_next = node_addr_reg;
      root_next = root_reg;
      root_hold_next = root_hold_reg;
      ibr_next = ibr_reg;
      gap_next = gap_reg;
      gap_seen_next = gap_seen_reg;
      sf_next = sf_reg;
      pd_next = pd_reg;
      loop_int_next = loop_int_reg;
      cps_int_next = cps_int_reg;
      ir_next = ir_reg;
      child_next = child_reg;
      con_next = con_reg;
      // Line states masked while a port carries data; valid only when idle or arbitrating
      for (int i = 0; i < NUM_PORTS; i++) begin
         la_next[2*i +: 2] = (port_busy_in[i] || startup) ? ppsr_pkg::LINE_INVALID : pa_sync[2*i +: 2];
         lb_next[2*i +: 2] = (port_busy_in[i] || startup) ? ppsr_pkg::LINE_INVALID : pb_sync[2*i +: 2];
      end
      if (wr_bus) begin
         root_hold_next = reg_wdata_in[ppsr_pkg::BUS_RHB_BIT];
         ibr_next = reg_wdata_in[ppsr_pkg::BUS_IBR_BIT];
      end
      if (wr_cfg) begin
         sf_next = reg_wdata_in[ppsr_pkg::CFG_SF_BIT];
         pd_next = reg_wdata_in[ppsr_pkg::CFG_PD_BIT];
      end
      if (wr_int) begin
         // Writing 1 cannot set an interrupt; only 0 clears
         if (!reg_wdata_in[ppsr_pkg::INT_LOOP_BIT]) loop_int_next = 1'b0;
         if (!reg_wdata_in[ppsr_pkg::INT_CPS_BIT]) cps_int_next = 1'b0;
         ir_next = reg_wdata_in[ppsr_pkg::INT_IR_BIT];
      end
      if (bus_reset_in) begin
         root_next = 1'b0;
         ibr_next = 1'b0;
         ir_next = own_reset_reg;
         con_next = conn_status_out;
         gap_seen_next = 1'b1;
         if (gap_seen_reg) gap_next = ppsr_pkg::GAP_COUNT_RESET;
      end
      if (wr_bus) begin
         gap_next = reg_wdata_in[ppsr_pkg::BUS_GAP_LSB +: 6];
         gap_seen_next = 1'b0;
      end else if (gap_cfg_valid_in) begin
         gap_next = gap_cfg_in;
         gap_seen_next = 1'b0;
      end
      if (treeid_done_in) begin
         root_next = startup ? 1'b1 : is_root_in;
         child_next = startup ? '1 : child_in;
      end
      if (selfid_done_in) begin
         node_addr_next = startup ? ppsr_pkg::STARTUP_NODE_ADDR : node_address_in;
         if (startup) root_next = 1'b1;
      end
      // Set wins over a clear in the same cycle
      if (loop_timeout_in) loop_int_next = 1'b1;
      if (!cps_sync) cps_int_next = 1'b1;
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         node_addr_reg <= ppsr_pkg::STARTUP_NODE_ADDR;
         root_reg <= 1'b0;
         root_hold_reg <= 1'b0;
         ibr_reg <= 1'b0;
         gap_reg <= ppsr_pkg::GAP_COUNT_RESET;
         gap_seen_reg <= 1'b0;
         sf_reg <= 1'b0;
         pd_reg <= 1'b0;
         loop_int_reg <= 1'b0;
         cps_int_reg <= 1'b0;
         ir_reg <= 1'b0;
         child_reg <= '0;
         con_reg <= '1;
         la_reg <= '0;
         lb_reg <= '0;
      end else begin
         node_addr_reg <= node_addr_next;
         root_reg <= root_next;
         root_hold_reg <= root_hold_next;
         ibr_reg <= ibr_next;
         gap_reg <= gap_next;
         gap_seen_reg <= gap_seen_next;
         sf_reg <= sf_next;
         pd_reg <= pd_next;
         loop_int_reg <= loop_int_next;
         cps_int_reg <= cps_int_next;
         ir_reg <= ir_next;
         child_reg <= child_next;
         con_reg <= con_next;
         la_reg <= la_next;
         lb_reg <= lb_next;
      end
   end

   assign gap_count_out = gap_reg;

   // -----------------------------------------------------------------
   // Read path
   // -----------------------------------------------------------------
   function automatic logic [7:0] port_byte(input int p);
      port_byte = 8'h00;
      if (p < NUM_PORTS) port_byte = {2'b00, con_reg[p], child_reg[p], lb_reg[2*p +: 2], la_reg[2*p +: 2]};
   endfunction : port_byte

   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg;
   logic [3:0] port_count;

   assign port_count = 4'(NUM_PORTS);

   always_comb begin
      rdata_next = 8'h00;
      case (reg_addr_in)
         ppsr_pkg::ADDR_NODE_IDENTITY: rdata_next = {cps_sync, root_reg, node_addr_reg};
         ppsr_pkg::ADDR_BUS_CONTROL: rdata_next = {gap_reg, ibr_reg, root_hold_reg};
         ppsr_pkg::ADDR_NODE_CONFIG: rdata_next = {port_count, REVISION, pd_reg, sf_reg};
         ppsr_pkg::ADDR_PORT1_STATUS: rdata_next = port_byte(0);
         ppsr_pkg::ADDR_PORT2_STATUS: rdata_next = port_byte(1);
         ppsr_pkg::ADDR_PORT3_STATUS: rdata_next = port_byte(2);
         ppsr_pkg::ADDR_INT_FLAGS: rdata_next = {bm_sync, 3'h0, ir_reg, cps_sync, cps_int_reg, loop_int_reg};
         default: rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rdata_reg <= reg_rd_in ? rdata_next : rdata_reg;
         rvalid_reg <= reg_rd_in;
      end
   end

   assign reg_rdata_out = rdata_reg;
   assign reg_rvalid_out = rvalid_reg;

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);

   rsvd_read_zero_a: assert property (
      reg_rd_in && reg_addr_in >= ppsr_pkg::ADDR_RESERVED_SEVEN |=> reg_rvalid_out && reg_rdata_out == 8'h00)
      else $error("reserved location read nonzero");

   cps_int_set_a: assert property (!cps_sync |=> cps_int_reg)
      else $error("cable power interrupt not set while power low");

   disc_reset_a: assert property (state_reg == ST_RUN && |disc_evt |=> bus_reset_out)
      else $error("disconnect did not start bus reset");

   ibr_reset_a: assert property (state_reg == ST_RUN && write_ibr |=> bus_reset_out ##1 !bus_reset_out)
      else $error("reset request write did not pulse bus reset");

   startup_root_a: assert property (startup && selfid_done_in |=> root_reg && node_addr_reg == 6'h00)
      else $error("startup self-id did not report root at address zero");

   quiet_ports_a: assert property (startup |-> ports_quiet_out && conn_status_out == '0)
      else $error("ports not quiet or connected during startup");

   gap_restore_a: assert property (
      bus_reset_in && gap_seen_reg && !wr_bus && !gap_cfg_valid_in |=> gap_count_out == 6'h3F)
      else $error("gap count not restored after two resets");

   busy_invalid_a: assert property (
      port_busy_in[NUM_PORTS-1] |=> la_reg[2*NUM_PORTS-1 -: 2] == 2'h0 && lb_reg[2*NUM_PORTS-1 -: 2] == 2'h0)
      else $error("line state not invalid while port busy");

   second_reset_a: assert property (state_reg == ST_QUIET && selfid_done_in && |stable |=> bus_reset_out)
      else $error("no second bus reset after debounced connection");

endmodule : ppsr_registers

`default_nettype wire

// ---- design/ppsr_pkg.sv ----
// Constants shared by the port status register bank
//
// Operation
// - Nine 8-bit locations at addresses 0 to 8; locations 7 and 8 are reserved.
// - Location 0: address, root, cable power; 1: root-hold, reset request, gap; 2: config.
// - Locations 3-5 report one port each; location 6 holds interrupts and flags.
// - Pair A line state: 11 high-Z, 01 one, 10 zero, 00 invalid.
// - Pair B line state uses the same two-bit encoding as pair A.
// - Line states reset to invalid and read invalid while the port transmits or receives.
// - Line states are only meaningful during arbitration or idle bus.
// - Bus-manager bit mirrors its pin and is advertised in self-identification.
// - Child flag 1 for child, 0 for parent; undefined until tree identification ends.
// - Connection flag set by hardware reset, refreshed with cable state on bus reset.
// - New connection triggers bus reset only after 335 ms of stable status.
// - A disconnection starts a bus reset at once.
// - After hardware reset all ports count as disconnected children for the first sequence.
// - No cable signalling during that first sequence.
// - At end of that self-identification report root with node address 00h.
// - A debounced real connection then starts a second, normal bus reset.
// - Cable power interrupt sets while power input is low; write 0 clears.
// - Loop interrupt sets on tree identification timeout; write 0 clears.
// - Gap count returns to 3Fh on hardware reset or two resets without update.
// - Writing 1 to reset request starts a bus reset; bit clears on any reset. The code starts one only in ST_RUN, not during the start-up sequence.

package ppsr_pkg;

   // -----------------------------------------------------------------
   // Register map
   // -----------------------------------------------------------------
   localparam logic [3:0] ADDR_NODE_IDENTITY = 4'h0;
   localparam logic [3:0] ADDR_BUS_CONTROL = 4'h1;
   localparam logic [3:0] ADDR_NODE_CONFIG = 4'h2;
   localparam logic [3:0] ADDR_PORT1_STATUS = 4'h3;
   localparam logic [3:0] ADDR_PORT2_STATUS = 4'h4;
   localparam logic [3:0] ADDR_PORT3_STATUS = 4'h5;
   localparam logic [3:0] ADDR_INT_FLAGS = 4'h6;
   localparam logic [3:0] ADDR_RESERVED_SEVEN = 4'h7;
   localparam logic [3:0] ADDR_RESERVED_EIGHT = 4'h8;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int BUS_RHB_BIT = 0;
   localparam int BUS_IBR_BIT = 1;
   localparam int BUS_GAP_LSB = 2;
   localparam int CFG_SF_BIT = 0;
   localparam int CFG_PD_BIT = 1;
   localparam int INT_LOOP_BIT = 0;
   localparam int INT_CPS_BIT = 1;
   localparam int INT_IR_BIT = 3;

   // -----------------------------------------------------------------
   // Values and encodings
   // -----------------------------------------------------------------
   localparam logic [5:0] GAP_COUNT_RESET = 6'h3F;
   localparam logic [5:0] STARTUP_NODE_ADDR = 6'h00;
   localparam logic [1:0] LINE_HIGH_Z = 2'h3;
   localparam logic [1:0] LINE_ONE = 2'h1;
   localparam logic [1:0] LINE_ZERO = 2'h2;
   localparam logic [1:0] LINE_INVALID = 2'h0;
   localparam int MAX_PORTS = 3;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int CLK_FREQ_KHZ = 125000;
   localparam int DEBOUNCE_MS = 335;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_FREQ_KHZ;

endpackage : ppsr_pkg

// ---- design/ppsr_sync2.sv ----
// Two-stage synchroniser for asynchronous pin levels
`timescale 1ns/100ps
`default_nettype none

module ppsr_sync2 #(
   parameter int WIDTH = 1
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;

   initial begin
      if (WIDTH < 1) $error("ppsr_sync2: WIDTH must be at least 1");
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= async_in;
         sync_reg <= meta_reg;
      end
   end

   assign sync_out = sync_reg;

endmodule : ppsr_sync2

`default_nettype wire

// ---- design/ppsr_debounce.sv ----
// Connection debounce for one cable port
`timescale 1ns/100ps
`default_nettype none

module ppsr_debounce #(
   parameter int unsigned DEBOUNCE_CYCLES = 100
) (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic raw_connect_in,
   output logic stable_out,
   output logic connect_evt_out,
   output logic disconnect_evt_out
);

   localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(DEBOUNCE_CYCLES - 1);

   logic [CW-1:0] cnt_reg, cnt_next;
   logic stable_reg, stable_next;
   logic conn_reg, conn_next;
   logic disc_reg, disc_next;

   initial begin
      if (DEBOUNCE_CYCLES < 1) $error("ppsr_debounce: DEBOUNCE_CYCLES must be at least 1");
   end

   always_comb begin
      cnt_next = cnt_reg;
      stable_next = stable_reg;
      conn_next = 1'b0;
      disc_next = 1'b0;
      if (!raw_connect_in) begin
         // Loss is reported at once, no filtering
         cnt_next = '0;
         stable_next = 1'b0;
         disc_next = stable_reg;
      end else if (!stable_reg) begin
         if (cnt_reg == LAST) begin
            stable_next = 1'b1;
            conn_next = 1'b1;
         end else begin
            cnt_next = cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         cnt_reg <= '0;
         stable_reg <= 1'b0;
         conn_reg <= 1'b0;
         disc_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         stable_reg <= stable_next;
         conn_reg <= conn_next;
         disc_reg <= disc_next;
      end
   end

   assign stable_out = stable_reg;
   assign connect_evt_out = conn_reg;
   assign disconnect_evt_out = disc_reg;

   stable_hold_a: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
      $rose(stable_reg) |-> $past(raw_connect_in) && cnt_reg == LAST)
      else $error("connection became stable before debounce expired");

endmodule : ppsr_debounce

`default_nettype wire

// ---- tb/ppsr_arbiter_model.sv ----
// Arbiter model answering each bus reset request with a configuration sequence
`timescale 1ns/100ps
`default_nettype none

module ppsr_arbiter_model (
   input wire logic ref_clk_in,
   input wire logic sys_rst_in,
   input wire logic reset_req_in,
   output logic bus_reset_out,
   output logic treeid_done_out,
   output logic selfid_done_out,
   output logic [5:0] node_address_out
);
   logic [3:0] step_reg;

   // A new request restarts the sequence, as a real bus reset would
   always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
      if (sys_rst_in)
         step_reg <= 4'h0;
      else if (reset_req_in)
         step_reg <= 4'h1;
      else if (step_reg != 4'h0)
         step_reg <= (step_reg == 4'h7) ? 4'h0 : step_reg + 4'h1;
   end

   assign bus_reset_out = (step_reg == 4'h2);
   assign treeid_done_out = (step_reg == 4'h4);
   assign selfid_done_out = (step_reg == 4'h6);
   // Nonzero so a forced startup address is visible
   assign node_address_out = 6'h05;
endmodule : ppsr_arbiter_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the port status register bank
`timescale 1ns/100ps
`default_nettype none

module testbench;
   // Short debounce keeps the run brief and lets it end before startup self-id
   localparam int DEB = 4;
   logic ref_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [3:0] reg_addr_in = 4'h0;
   logic reg_rd_in = 1'b0;
   logic reg_wr_in = 1'b0;
   logic [7:0] reg_wdata_in = 8'h00;
   logic cable_power_in = 1'b1;
   logic bm_capable_in = 1'b1;
   logic [2:0] cable_connect_in = 3'h0;
   logic [5:0] pair_a = 6'h27;
   logic [5:0] pair_b = 6'h39;
   logic [2:0] port_busy = 3'h4;
   logic loop_timeout_in = 1'b0;
   logic gap_cfg_valid_in = 1'b0;
   logic [5:0] gap_cfg_in = 6'h00;
   logic [7:0] reg_rdata_out;
   logic reg_rvalid_out, bus_reset_out, ports_quiet_out, bm_capable_out;
   logic bus_reset_in, treeid_done_in, selfid_done_in;
   logic [5:0] node_address_in, gap_count_out;
   logic [2:0] conn_status_out, startup_child_out;
   int num_errors = 0;
   int n_checks = 0;
   int n;
   logic [12:0] rows [0:14] = '{13'h0085, 13'h10FF, 13'h0085, 13'h1154, 13'h0154, 13'h0230, 13'h13FF,
      13'h0337, 13'h0409, 13'h0510, 13'h068C, 13'h17FF, 13'h0700, 13'h0800, 13'h0F00};

   ppsr_registers #(.DEBOUNCE_CYCLES(DEB)) i_ppsr_registers (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in),
      .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out), .cable_power_in(cable_power_in),
      .bm_capable_in(bm_capable_in), .cable_connect_in(cable_connect_in), .cable_pair_a_in(pair_a),
      .cable_pair_b_in(pair_b), .bus_reset_in(bus_reset_in), .treeid_done_in(treeid_done_in),
      .selfid_done_in(selfid_done_in), .is_root_in(1'b0), .node_address_in(node_address_in),
      .child_in(3'h5), .port_busy_in(port_busy), .loop_timeout_in(loop_timeout_in),
      .gap_cfg_valid_in(gap_cfg_valid_in), .gap_cfg_in(gap_cfg_in), .bus_reset_out(bus_reset_out),
      .ports_quiet_out(ports_quiet_out), .conn_status_out(conn_status_out),
      .startup_child_out(startup_child_out), .bm_capable_out(bm_capable_out), .gap_count_out(gap_count_out));

   ppsr_arbiter_model i_ppsr_arbiter_model (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
      .reset_req_in(bus_reset_out), .bus_reset_out(bus_reset_in), .treeid_done_out(treeid_done_in),
      .selfid_done_out(selfid_done_in), .node_address_out(node_address_in));

   initial begin
      forever #4 ref_clk_in = ~ref_clk_in;
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic results;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : results

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge ref_clk_in);
      reg_rd_in <= 1'b0;
      #1;
      chk("read valid", 8'h01, {7'h0, reg_rvalid_out});
      chk("read data", exp, reg_rdata_out);
   endtask : rd

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge ref_clk_in);
      reg_wr_in <= 1'b0;
   endtask : wr

   // Counts cycles to the reset request, then lets the arbiter sequence finish
   task automatic wait_req(input int lim, output int cnt);
      cnt = 0;
      // Step off the edge so a pulse launched by it is seen
      #1;
      while (bus_reset_out !== 1'b1 && cnt < lim) begin
         @(posedge ref_clk_in);
         #1;
         cnt++;
      end
      if (bus_reset_out !== 1'b1) begin
         num_errors++;
         $display("wrong value reset request expected 1 seen %b", bus_reset_out);
         results();
      end
      repeat (12) @(posedge ref_clk_in);
   endtask : wait_req

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (12) @(posedge ref_clk_in);
      chk("quiet in reset", 8'h01, {7'h0, ports_quiet_out});
      chk("conn in reset", 8'h00, {5'h0, conn_status_out});
      chk("child in reset", 8'h07, {5'h0, startup_child_out});
      chk("gap in reset", 8'h3F, {2'h0, gap_count_out});
      sys_rst_in <= 1'b0;
      wait_req(10, n);
      chk("quiet after startup", 8'h00, {7'h0, ports_quiet_out});
      rd(4'h0, 8'hC0);
      cable_connect_in <= 3'h1;
      wait_req(DEB + 30, n);
      chk("debounce held", 8'h01, {7'h0, n >= DEB});
      chk("conn status", 8'h01, {5'h0, conn_status_out});
      chk("bm pin", 8'h01, {7'h0, bm_capable_out});
      foreach (rows[i]) begin
         if (rows[i][12])
            wr(rows[i][11:8], rows[i][7:0]);
         else
            rd(rows[i][11:8], rows[i][7:0]);
      end
      // Power drop while clear is attempted: set must win
      cable_power_in <= 1'b0;
      loop_timeout_in <= 1'b1;
      @(posedge ref_clk_in);
      loop_timeout_in <= 1'b0;
      repeat (4) @(posedge ref_clk_in);
      rd(4'h6, 8'h8B);
      wr(4'h6, 8'h08);
      rd(4'h6, 8'h8A);
      cable_power_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      wr(4'h6, 8'h08);
      rd(4'h6, 8'h8C);
      wr(4'h1, 8'h56);
      wait_req(4, n);
      rd(4'h1, 8'h54);
      cable_connect_in <= 3'h0;
      wait_req(8, n);
      rd(4'h1, 8'hFC);
      rd(4'h3, 8'h17);
      @(posedge ref_clk_in);
      gap_cfg_in <= 6'h0A;
      gap_cfg_valid_in <= 1'b1;
      bm_capable_in <= 1'b0;
      @(posedge ref_clk_in);
      gap_cfg_valid_in <= 1'b0;
      rd(4'h1, 8'h28);
      chk("bm pin low", 8'h00, {7'h0, bm_capable_out});
      // Hardware reset in mid-run with a cable already plugged in
      cable_connect_in <= 3'h1;
      sys_rst_in <= 1'b1;
      repeat (3) @(posedge ref_clk_in);
      chk("gap in reset", 8'h3F, {2'h0, gap_count_out});
      chk("quiet in reset", 8'h01, {7'h0, ports_quiet_out});
      sys_rst_in <= 1'b0;
      wait_req(10, n);
      rd(4'h3, 8'h37);
      results();
   end
endmodule : testbench
`default_nettype wire
